/* File: shared/ddp_regs.svh */
// Register offsets, field positions and reset values of the DAC input port control block.
// Included by the port control top; holds definitions only.
`ifndef DDP_REGS_SVH
`define DDP_REGS_SVH

// Register indices; the byte address is four times the index.
`define DDP_IDX_CFG 6'h00
`define DDP_IDX_CLK 6'h02
`define DDP_IDX_STATUS 6'h04
`define DDP_IDX_IRQ_STAT 6'h05
`define DDP_IDX_IRQ_CLR 6'h06
`define DDP_IDX_IRQ_EN 6'h07
`define DDP_IDX_I_WORD 6'h08
`define DDP_IDX_Q_WORD 6'h09

// Configuration register at index 0.
`define DDP_CFG_ONE_PORT 0
`define DDP_CFG_PLL_EN 1
`define DDP_CFG_SOFT_RESET 5
`define DDP_CFG_RST 8'h00

// Clock control register at index 2.
`define DDP_CLK_DEV_DRIVE 3
`define DDP_CLK_RST 8'h00

// Status register fields.
`define DDP_STAT_LOCKED 0
`define DDP_STAT_BIT14 1
`define DDP_STAT_EXT_CLK 2

// Interrupt event bits.
`define DDP_EV_I_LOAD 0
`define DDP_EV_Q_LOAD 1
`define DDP_EV_LOCK_LOST 2
`define DDP_EV_LOCK_GAINED 3
`define DDP_EV_W 4
`define DDP_IRQ_RST 4'h0

`endif

/* File: shared/ddp_pkg.sv */
// Types shared by the DAC input port control block.
// Assumes nothing of its surroundings.
`default_nettype none
package ddp_pkg;
   typedef enum logic {DDP_TWO_PORT = 1'b0, DDP_ONE_PORT = 1'b1} ddp_mode_t;
endpackage
`default_nettype wire

/* File: shared/ddp_cap_if.sv */
// Carrier between the port control top and its word capture unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ddp_cap_if #(parameter int WORD_W = 12);
   logic rise;
   ddp_pkg::ddp_mode_t mode;
   logic sel;
   logic [WORD_W-1:0] port1;
   logic [WORD_W-2:0] port2;
   logic [WORD_W-1:0] i_word;
   logic [WORD_W-1:0] q_word;
   logic i_load;
   logic q_load;
   modport ctl(output rise, output mode, output sel, output port1, output port2,
      input i_word, input q_word, input i_load, input q_load);
   modport cap(input rise, input mode, input sel, input port1, input port2,
      output i_word, output q_word, output i_load, output q_load);
endinterface
`default_nettype wire

/* File: rtl/ddp_capture.sv */
// Word capture unit: latches port words into the I and Q input registers.
// Assumes synchronised pin levels and a one-cycle latch edge pulse from the top.
`timescale 1ns/1ps
`default_nettype none
module ddp_capture #(parameter int WORD_W = 12)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Capture carrier
   ddp_cap_if.cap bus
);
   logic [WORD_W-1:0] i_word_ff;
   logic [WORD_W-1:0] q_word_ff;
   logic i_load_ff;
   logic q_load_ff;
   wire one_port = (bus.mode == ddp_pkg::DDP_ONE_PORT);
   // In two-port mode both registers load on every edge.
   wire ld_i = bus.rise & (~one_port | bus.sel);
   wire ld_q = bus.rise & (~one_port | ~bus.sel);
   // The select pin is the top bit of port 2 when two ports are in use.
   wire [WORD_W-1:0] q_src = one_port ? bus.port1 : {bus.sel, bus.port2};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         i_word_ff <= '0;
         q_word_ff <= '0;
         i_load_ff <= 1'b0;
         q_load_ff <= 1'b0;
      end
      else
      begin
         if (ld_i)
            i_word_ff <= bus.port1;
         if (ld_q)
            q_word_ff <= q_src;
         i_load_ff <= ld_i;
         q_load_ff <= ld_q;
      end
   end

   assign bus.i_word = i_word_ff;
   assign bus.q_word = q_word_ff;
   assign bus.i_load = i_load_ff;
   assign bus.q_load = q_load_ff;

   AST_ONE_PORT_I:
   assert property (@(posedge clk) disable iff (!rst_n)
      bus.rise && one_port && bus.sel |=> i_word_ff == $past(bus.port1) && $stable(q_word_ff))
   else $error("I word not latched with select high");

   AST_ONE_PORT_Q:
   assert property (@(posedge clk) disable iff (!rst_n)
      bus.rise && one_port && !bus.sel |=> q_word_ff == $past(bus.port1) && $stable(i_word_ff))
   else $error("Q word not demultiplexed with select low");

   AST_TWO_PORT_MSB:
   assert property (@(posedge clk) disable iff (!rst_n)
      bus.rise && !one_port |=> q_word_ff[WORD_W-1] == $past(bus.sel)
      && i_word_ff == $past(bus.port1))
   else $error("Select pin not used as port 2 top bit");
endmodule
`default_nettype wire

/* File: rtl/ddp_port_ctrl.sv */
// Input port and pin mode control of a dual channel DAC, with a Wishbone register slave.
// Assumes all pins are asynchronous to CLK and the core takes words from flops.
`timescale 1ns/1ps
`default_nettype none
`include "ddp_regs.svh"
module ddp_port_ctrl #(parameter int WORD_W = 12)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [3:0] WB_SEL_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Device pins
   input wire logic DEVICE_CLOCK,
   input wire logic HW_RESET,
   input wire logic PLL_LOCKED,
   input wire logic CHANNEL_SELECT,
   input wire logic [WORD_W-1:0] FIRST_PORT_BITS,
   input wire logic [WORD_W-2:0] SECOND_PORT_BITS,
   // Shared lock or data clock pin
   input wire logic LOCK_OR_DATA_CLOCK_PIN_I,
   output logic LOCK_OR_DATA_CLOCK_PIN_O,
   output logic LOCK_OR_DATA_CLOCK_PIN_OE,
   // Shared single port clock or bit fourteen pin
   input wire logic SECOND_PORT_BIT_FOURTEEN_I,
   output logic SINGLE_PORT_CLOCK_OUT_O,
   output logic SINGLE_PORT_CLOCK_OUT_OE,
   // Core side
   output logic [WORD_W-1:0] I_WORD,
   output logic [WORD_W-1:0] Q_WORD,
   output logic WORD_STROBE,
   output logic IRQ
);
   localparam int SW = 2 * WORD_W + 5;
   localparam int B = 2 * WORD_W - 1;

   if (WORD_W < 2 || WORD_W > 32)
   begin : g_check
      $error("WORD_W must lie between 2 and 32");
   end

   // Pin synchroniser: every pin passes two flops before use.
   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   wire [SW-1:0] pin_vec = {DEVICE_CLOCK, LOCK_OR_DATA_CLOCK_PIN_I, SECOND_PORT_BIT_FOURTEEN_I,
      CHANNEL_SELECT, PLL_LOCKED, HW_RESET, SECOND_PORT_BITS, FIRST_PORT_BITS};

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= pin_vec;
         sync2_ff <= sync1_ff;
      end
   end

   wire [WORD_W-1:0] port1_s = sync2_ff[WORD_W-1:0];
   wire [WORD_W-2:0] port2_s = sync2_ff[B-1:WORD_W];
   wire hw_rst_s = sync2_ff[B];
   wire lock_s = sync2_ff[B+1];
   wire sel_s = sync2_ff[B+2];
   wire bit14_s = sync2_ff[B+3];
   wire lockpin_s = sync2_ff[B+4];
   wire devclk_s = sync2_ff[B+5];

   // Register state.
   logic [7:0] cfg_ff;
   logic [7:0] clkreg_ff;
   logic [`DDP_EV_W-1:0] irq_stat_ff;
   logic [`DDP_EV_W-1:0] irq_en_ff;
   logic ack_ff;
   logic [31:0] dat_ff;

   // Bus decode; a write takes effect on the edge that sees ack high.
   wire req = WB_CYC_I & WB_STB_I;
   wire [5:0] idx = WB_ADR_I[7:2];
   wire wr_en = req & WB_WE_I & ack_ff & WB_SEL_I[0];
   wire hit_cfg = (idx == `DDP_IDX_CFG);
   wire hit_clk = (idx == `DDP_IDX_CLK);
   wire hit_stat = (idx == `DDP_IDX_STATUS);
   wire hit_istat = (idx == `DDP_IDX_IRQ_STAT);
   wire hit_iclr = (idx == `DDP_IDX_IRQ_CLR);
   wire hit_ien = (idx == `DDP_IDX_IRQ_EN);
   wire hit_i = (idx == `DDP_IDX_I_WORD);
   wire hit_q = (idx == `DDP_IDX_Q_WORD);
   wire soft_rst = wr_en & hit_cfg & WB_DAT_I[`DDP_CFG_SOFT_RESET];
   // Index 0 is outside the software reset; the reset write itself is not stored either.
   wire cfg_wr = wr_en & hit_cfg & ~WB_DAT_I[`DDP_CFG_SOFT_RESET];
   wire regs_rst = hw_rst_s | soft_rst;

   // Mode decode.
   wire pll_en = cfg_ff[`DDP_CFG_PLL_EN];
   wire one_port = cfg_ff[`DDP_CFG_ONE_PORT];
   wire dev_drive = clkreg_ff[`DDP_CLK_DEV_DRIVE];
   // The source supplies the data clock on the shared pin in two-port mode with the PLL off when the device does not drive it.
   wire ext_dclk = ~pll_en & ~one_port & ~dev_drive;
   wire latch_clk = ext_dclk ? lockpin_s : devclk_s;

   // Latch edge detection on the selected clock.
   logic latch_prev_ff;
   logic lock_prev_ff;
   wire rise = latch_clk & ~latch_prev_ff;

   ddp_cap_if #(.WORD_W(WORD_W)) cap_bus ();
   assign cap_bus.rise = rise;
   assign cap_bus.mode = ddp_pkg::ddp_mode_t'(one_port);
   assign cap_bus.sel = sel_s;
   assign cap_bus.port1 = port1_s;
   assign cap_bus.port2 = port2_s;

   ddp_capture #(.WORD_W(WORD_W)) u_capture
   (
      .clk(CLK),
      .rst_n(RST_N),
      .bus(cap_bus)
   );

   // Interrupt events; a set in the same cycle as a clear wins.
   wire [`DDP_EV_W-1:0] events = {pll_en & lock_s & ~lock_prev_ff,
      pll_en & ~lock_s & lock_prev_ff, cap_bus.q_load, cap_bus.i_load};
   wire [`DDP_EV_W-1:0] irq_clr = (wr_en & hit_iclr) ? WB_DAT_I[`DDP_EV_W-1:0] : `DDP_IRQ_RST;

   wire [7:0] nxt_cfg = hw_rst_s ? `DDP_CFG_RST :
      cfg_wr ? (WB_DAT_I[7:0] & ~(8'h01 << `DDP_CFG_SOFT_RESET)) : cfg_ff;
   wire [7:0] nxt_clkreg = regs_rst ? `DDP_CLK_RST :
      (wr_en & hit_clk) ? WB_DAT_I[7:0] : clkreg_ff;
   wire [`DDP_EV_W-1:0] nxt_irq_stat = regs_rst ? `DDP_IRQ_RST :
      ((irq_stat_ff & ~irq_clr) | events);
   wire [`DDP_EV_W-1:0] nxt_irq_en = regs_rst ? `DDP_IRQ_RST :
      (wr_en & hit_ien) ? WB_DAT_I[`DDP_EV_W-1:0] : irq_en_ff;

   // Pin drive: lock state with the PLL on, else a copy of the device clock.
   wire nxt_lock_oe = pll_en | (~one_port & dev_drive);
   wire nxt_lock_out = pll_en ? lock_s : devclk_s;
   wire nxt_spc_oe = ~pll_en & one_port;
   // One word per device clock period is twice the per-channel rate.
   wire nxt_spc_out = devclk_s;

   wire [2:0] status = {ext_dclk, bit14_s, lock_s};
   wire [31:0] rd_data = hit_cfg ? {24'h000000, cfg_ff} :
      hit_clk ? {24'h000000, clkreg_ff} :
      hit_stat ? {29'h0, status} :
      hit_istat ? {28'h0, irq_stat_ff} :
      hit_ien ? {28'h0, irq_en_ff} :
      hit_i ? 32'(cap_bus.i_word) :
      hit_q ? 32'(cap_bus.q_word) : 32'h00000000;

   logic lock_pin_out_ff;
   logic lock_pin_oe_ff;
   logic spc_out_ff;
   logic spc_oe_ff;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cfg_ff <= `DDP_CFG_RST;
         clkreg_ff <= `DDP_CLK_RST;
         irq_stat_ff <= `DDP_IRQ_RST;
         irq_en_ff <= `DDP_IRQ_RST;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         clkreg_ff <= nxt_clkreg;
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff <= nxt_irq_en;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff)
            dat_ff <= rd_data;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         latch_prev_ff <= 1'b0;
         lock_prev_ff <= 1'b0;
         lock_pin_out_ff <= 1'b0;
         lock_pin_oe_ff <= 1'b0;
         spc_out_ff <= 1'b0;
         spc_oe_ff <= 1'b0;
      end
      else
      begin
         latch_prev_ff <= latch_clk;
         lock_prev_ff <= lock_s;
         lock_pin_out_ff <= nxt_lock_out;
         lock_pin_oe_ff <= nxt_lock_oe;
         spc_out_ff <= nxt_spc_out;
         spc_oe_ff <= nxt_spc_oe;
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = dat_ff;
   assign LOCK_OR_DATA_CLOCK_PIN_O = lock_pin_out_ff;
   assign LOCK_OR_DATA_CLOCK_PIN_OE = lock_pin_oe_ff;
   assign SINGLE_PORT_CLOCK_OUT_O = spc_out_ff;
   assign SINGLE_PORT_CLOCK_OUT_OE = spc_oe_ff;
   assign I_WORD = cap_bus.i_word;
   assign Q_WORD = cap_bus.q_word;
   assign WORD_STROBE = cap_bus.i_load | cap_bus.q_load;
   assign IRQ = |(irq_stat_ff & irq_en_ff);

   AST_LOCK_PIN:
   assert property (@(posedge CLK) disable iff (!RST_N)
      pll_en |=> lock_pin_oe_ff && lock_pin_out_ff == $past(lock_s))
   else $error("Lock pin does not follow PLL lock");

   AST_DATA_CLOCK_DRIVER:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !pll_en && !one_port |=> lock_pin_oe_ff == $past(dev_drive)
      && (!lock_pin_oe_ff || lock_pin_out_ff == $past(devclk_s)))
   else $error("Data clock pin driver does not match control bit");

   AST_HW_RESET:
   assert property (@(posedge CLK) disable iff (!RST_N)
      hw_rst_s |=> cfg_ff == `DDP_CFG_RST && clkreg_ff == `DDP_CLK_RST
      && irq_en_ff == `DDP_IRQ_RST)
   else $error("Hardware reset did not restore registers");

   AST_SOFT_RESET:
   assert property (@(posedge CLK) disable iff (!RST_N)
      soft_rst |=> clkreg_ff == `DDP_CLK_RST && irq_en_ff == `DDP_IRQ_RST
      && irq_stat_ff == `DDP_IRQ_RST)
   else $error("Software reset did not restore registers");

   AST_SOFT_KEEPS_CFG:
   assert property (@(posedge CLK) disable iff (!RST_N)
      soft_rst && !hw_rst_s |=> $stable(cfg_ff))
   else $error("Software reset changed index 0");

   AST_SINGLE_PORT_CLOCK:
   assert property (@(posedge CLK) disable iff (!RST_N)
      one_port && !pll_en |=> spc_oe_ff && spc_out_ff == $past(devclk_s))
   else $error("Single port clock not driven");

   AST_SPC_QUIET:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !one_port || pll_en |=> !spc_oe_ff)
   else $error("Single port clock driven outside its mode");

   // Bus handshake, register access, interrupt register and word strobe checks.
   AST_ACK_ANSWER:
   assert property (@(posedge CLK) disable iff (!RST_N)
      req && !ack_ff |=> ack_ff)
   else $error("Bus request not answered in the next cycle");

   AST_ACK_PULSE:
   assert property (@(posedge CLK) disable iff (!RST_N)
      ack_ff |=> !ack_ff)
   else $error("Acknowledge held for more than one cycle");

   AST_ACK_NEEDS_REQ:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !req |=> !ack_ff)
   else $error("Acknowledge given without a request");

   AST_READ_CFG:
   assert property (@(posedge CLK) disable iff (!RST_N)
      req && !ack_ff && hit_cfg |=> dat_ff == {24'h000000, $past(cfg_ff)})
   else $error("Read data of index 0 does not match the register");

   AST_CLEAR_READS_ZERO:
   assert property (@(posedge CLK) disable iff (!RST_N)
      req && !ack_ff && hit_iclr |=> dat_ff == 32'h00000000)
   else $error("Clear register did not read as zero");

   AST_CFG_STORE:
   assert property (@(posedge CLK) disable iff (!RST_N)
      cfg_wr && !hw_rst_s |=> cfg_ff == ($past(WB_DAT_I[7:0]) & 8'hdf))
   else $error("Index 0 write not stored with the reset bit clear");

   AST_SEL_IGNORED:
   assert property (@(posedge CLK) disable iff (!RST_N)
      req && WB_WE_I && ack_ff && !WB_SEL_I[0] && !hw_rst_s
      |=> $stable(cfg_ff) && $stable(clkreg_ff) && $stable(irq_en_ff))
   else $error("Write without byte 0 selected changed a register");

   AST_ENABLE_STORE:
   assert property (@(posedge CLK) disable iff (!RST_N)
      wr_en && hit_ien && !regs_rst |=> irq_en_ff == $past(WB_DAT_I[`DDP_EV_W-1:0]))
   else $error("Interrupt enable write not stored");

   AST_EVENT_SETS:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !regs_rst |=> (irq_stat_ff & $past(events)) == $past(events))
   else $error("Interrupt event lost against a clear");

   AST_CLEAR_BITS:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !regs_rst && events == `DDP_IRQ_RST
      |=> (irq_stat_ff & $past(irq_clr)) == `DDP_IRQ_RST)
   else $error("Interrupt status bit not cleared");

   AST_STICKY:
   assert property (@(posedge CLK) disable iff (!RST_N)
      !regs_rst && events == `DDP_IRQ_RST && irq_clr == `DDP_IRQ_RST
      |=> $stable(irq_stat_ff))
   else $error("Interrupt status changed without event or clear");

   AST_HW_CLEARS_STAT:
   assert property (@(posedge CLK) disable iff (!RST_N)
      hw_rst_s |=> irq_stat_ff == `DDP_IRQ_RST)
   else $error("Hardware reset did not clear interrupt status");

   AST_STROBE_PULSE:
   assert property (@(posedge CLK) disable iff (!RST_N)
      WORD_STROBE |=> !WORD_STROBE)
   else $error("Word strobe longer than one cycle");
endmodule
`default_nettype wire

/* File: testbench/ddp_source.sv */
// Model of the baseband source that feeds the two data ports.
// Assumes calls to send come one at a time; the data clock stays low between words.
`timescale 1ns/1ps
`default_nettype none
module ddp_source
(
   // Source pins
   output logic data_clk,
   output logic sel,
   output logic [11:0] port1,
   output logic [10:0] port2
);
   initial
   begin
      data_clk = 1'b0;
      sel = 1'b0;
      port1 = 12'h000;
      port2 = 11'h000;
   end
   // Data is set up half a period before the rising edge and held to the end of the period.
   // Afterwards the lines show the inverse so that no stale word can pass for a fresh one.
   task automatic send(input logic s, input logic [11:0] a, input logic [10:0] b);
      begin
         sel = s;
         port1 = a;
         port2 = b;
         #24 data_clk = 1'b1;
         #24 data_clk = 1'b0;
         #24;
         sel = ~s;
         port1 = ~a;
         port2 = ~b;
      end
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench of the input port control block.
// Assumes the source model drives both the device clock and the shared pin when released.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic hw_reset = 1'b0;
   logic locked = 1'b0;
   logic bit14 = 1'b1;
   logic pin_o, pin_oe, spc_o, spc_oe, strobe, irq;
   logic [11:0] i_word, q_word;
   wire logic dclk, sel, pin;
   wire logic [11:0] p1;
   wire logic [10:0] p2;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int strobe_count = 0;
   int spc_rises = 0;
   int pin_rises = 0;
   logic spc_prev = 1'b0;
   logic pin_prev = 1'b0;
   logic [3:0] wsel = 4'hf;
   always #2 clk = ~clk;
   assign pin = pin_oe ? pin_o : dclk;
   ddp_source src (.data_clk(dclk), .sel(sel), .port1(p1), .port2(p2));
   ddp_port_ctrl DUT (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(wsel), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .DEVICE_CLOCK(dclk), .HW_RESET(hw_reset), .PLL_LOCKED(locked),
      .CHANNEL_SELECT(sel), .FIRST_PORT_BITS(p1), .SECOND_PORT_BITS(p2),
      .LOCK_OR_DATA_CLOCK_PIN_I(pin), .LOCK_OR_DATA_CLOCK_PIN_O(pin_o),
      .LOCK_OR_DATA_CLOCK_PIN_OE(pin_oe), .SECOND_PORT_BIT_FOURTEEN_I(bit14),
      .SINGLE_PORT_CLOCK_OUT_O(spc_o), .SINGLE_PORT_CLOCK_OUT_OE(spc_oe),
      .I_WORD(i_word), .Q_WORD(q_word), .WORD_STROBE(strobe), .IRQ(irq));
   task automatic complete_run();
      begin
         $display("checks %0d mismatches %0d", comparisons, bad_count);
         if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         comparisons++;
         if (got !== exp)
         begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One classic cycle; the request is held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, input logic [3:0] s = 4'hf);
      int n;
      begin
         n = 0;
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         wsel <= s;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (ack !== 1'b1);
         q = rdat;
         // The slave answers in the cycle after it takes the request, for one cycle only.
         chk(32'(n), 32'h2);
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         @(posedge clk);
         chk(32'(ack), 32'h0);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic [31:0] q;
      wb(1'b1, a, d, q, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffff_ffff);
      logic [31:0] q;
      begin
         wb(1'b0, a, 32'h0, q);
         chk(q & m, e);
      end
   endtask
   always @(posedge clk)
   begin
      cycles++;
      // Device-driven clock edges count only while the pin is driven.
      if (strobe === 1'b1)
         strobe_count++;
      if (spc_oe === 1'b1 && spc_o === 1'b1 && spc_prev === 1'b0)
         spc_rises++;
      if (pin_oe === 1'b1 && pin_o === 1'b1 && pin_prev === 1'b0)
         pin_rises++;
      spc_prev = spc_o;
      pin_prev = pin_o;
      if (cycles == 20000)
      begin
         bad_count++;
         complete_run();
      end
   end
   initial
   begin
      tick(2);
      rst_n <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h1c, 32'h0);
      rd(8'h3c, 32'h0);
      rd(8'h10, 32'h6, 32'h7);
      locked <= 1'b1;
      wr(8'h00, 32'h2);
      tick(5);
      chk(32'({pin_oe, pin_o}), 32'h3);
      rd(8'h10, 32'h1, 32'h5);
      locked <= 1'b0;
      tick(5);
      chk(32'({pin_oe, pin_o}), 32'h2);
      rd(8'h14, 32'h4, 32'hc);
      locked <= 1'b1;
      tick(5);
      chk(32'({pin_oe, pin_o}), 32'h3);
      rd(8'h14, 32'hc, 32'hc);
      locked <= 1'b0;
      tick(5);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h8);
      tick(2);
      chk(32'(pin_oe), 32'h1);
      // The device now drives the data clock; the lock indications were the first two rises.
      src.send(1'b0, 12'h3c5, 11'h0f0);
      tick(6);
      chk(32'(i_word), 32'h3c5);
      chk(32'(q_word), 32'h0f0);
      chk(32'(pin_rises), 32'h3);
      wr(8'h08, 32'h0);
      wr(8'h18, 32'hf);
      wr(8'h1c, 32'h1);
      tick(2);
      chk(32'(pin_oe), 32'h0);
      // The shared pin is now the latch clock, driven by the source.
      src.send(1'b1, 12'h5a3, 11'h2c1);
      tick(6);
      chk(32'(i_word), 32'h5a3);
      chk(32'(q_word), 32'hac1);
      chk(32'(irq), 32'h1);
      wr(8'h18, 32'hf);
      tick(1);
      chk(32'(irq), 32'h0);
      wr(8'h1c, 32'h0);
      wr(8'h00, 32'h1);
      tick(2);
      chk(32'({spc_oe, pin_oe}), 32'h2);
      src.send(1'b1, 12'h123, 11'h7ff);
      src.send(1'b0, 12'h456, 11'h000);
      tick(6);
      chk(32'(i_word), 32'h123);
      chk(32'(q_word), 32'h456);
      chk(32'(strobe_count), 32'h4);
      chk(32'(spc_rises), 32'h2);
      rd(8'h14, 32'h3, 32'h3);
      chk(32'(irq), 32'h0);
      wr(8'h08, 32'h8, 4'he);
      rd(8'h08, 32'h0);
      wr(8'h08, 32'h8);
      wr(8'h1c, 32'h1);
      wr(8'h00, 32'h20);
      rd(8'h00, 32'h1);
      rd(8'h08, 32'h0);
      rd(8'h1c, 32'h0);
      hw_reset <= 1'b1;
      tick(5);
      rd(8'h00, 32'h0);
      hw_reset <= 1'b0;
      tick(5);
      complete_run();
   end
endmodule
`default_nettype wire
